//--- hw/arhf_formatter.v
/*
 * asynchronous receive header formatter: takes one received packet's
 * decoded fields plus its payload quadlets and writes the stored entry
 * into the receive fifo, header quadlets first, data after.
 * assumes the link core holds pkt_* stable while pkt_valid is high and
 * until pkt_ready; payload quadlets are offered one by one on dat_*.
 */
`timescale 1ns/100ps
`include "arhf_regs.vh"
module arhf_formatter #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    input  wire         mclk,
    input  wire         resetn,
    input  wire         pkt_valid,
    output wire         pkt_ready,
    input  wire         pkt_block,
    input  wire         pkt_ptr_fetch,
    input  wire         pkt_no_ack,
    input  wire [3:0]   pkt_status_in,
    input  wire [1:0]   pkt_spd,
    input  wire [3:0]   pkt_ack,
    input  wire [9:0]   pkt_dst_bus,
    input  wire [5:0]   pkt_dst_node,
    input  wire [9:0]   pkt_src_bus,
    input  wire [5:0]   pkt_src_node,
    input  wire [5:0]   pkt_tlabel,
    input  wire [1:0]   retry_code,
    input  wire [3:0]   pkt_tcode,
    input  wire [3:0]   pkt_rcode,
    input  wire [47:0]  pkt_offset,
    input  wire [15:0]  pkt_length,
    input  wire [15:0]  pkt_ext_tcode,
    input  wire         dat_valid,
    output wire         dat_ready,
    input  wire [31:0]  dat_quad,
    output wire         async_receive_fifo_valid,
    input  wire         async_receive_fifo_ready,
    output wire [31:0]  async_receive_fifo_data,
    output wire         fifo_full,
    output wire         fifo_empty,
    output reg          entry_done,
    output reg  [3:0]   last_status_q
);
    // ----------------------------------------------------------------------
    // states
    // ----------------------------------------------------------------------
    localparam S_IDLE = 4'b0001;
    localparam S_HDR  = 4'b0010;
    localparam S_DATA = 4'b0100;
    localparam S_DONE = 4'b1000;

    // ----------------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------------
    function has_data;
        input [3:0] tc;
        begin
            case (tc)
                `ARHF_TC_WRQ_QUAD,
                `ARHF_TC_WRQ_BLK,
                `ARHF_TC_RD_RESP_QUAD,
                `ARHF_TC_RD_RESP_BLK,
                `ARHF_TC_LOCK_RQ,
                `ARHF_TC_LOCK_RESP: has_data = 1'b1;
                default:            has_data = 1'b0;
            endcase
        end
    endfunction

    function is_resp;
        input [3:0] tc;
        begin
            is_resp = (tc == `ARHF_TC_WR_RESP) ||
                      (tc == `ARHF_TC_RD_RESP_QUAD) ||
                      (tc == `ARHF_TC_RD_RESP_BLK) ||
                      (tc == `ARHF_TC_LOCK_RESP);
        end
    endfunction

    // ----------------------------------------------------------------------
    // status selection
    // ----------------------------------------------------------------------
    reg [3:0] status_d;
    always @* begin
        if (pkt_ptr_fetch)
            status_d = `ARHF_ST_PTR_FETCH;
        else if (is_resp(pkt_tcode) &&
                 pkt_rcode != `ARHF_RCODE_COMPLETE)
            status_d = `ARHF_ST_RCODE_BAD;
        else if (pkt_no_ack)
            status_d = `ARHF_ST_NO_ACK;
        else if (pkt_status_in >= `ARHF_ST_RSVD_LO)
            status_d = `ARHF_ST_ACK_COMPLETE;
        else
            status_d = pkt_status_in;
    end

    // undefined speed is replaced by ARHF_SPD_100 rather than stored
    wire [1:0] spd_w = (pkt_spd == `ARHF_SPD_UNDEF) ?
                       `ARHF_SPD_100 : pkt_spd;

    // ----------------------------------------------------------------------
    // header quadlets
    // ----------------------------------------------------------------------
    wire [31:0] q0 = ({28'h0000000, status_d} << `ARHF_Q0_STATUS_LSB)
                   | ({30'h00000000, spd_w} << `ARHF_Q0_SPD_LSB)
                   | {28'h0000000, pkt_ack};
    wire [15:0] dst_id = {pkt_dst_bus, pkt_dst_node};
    wire [15:0] src_id = {pkt_src_bus, pkt_src_node};
    wire [15:0] q1_lo  = ({10'h000, pkt_tlabel} << `ARHF_Q1_TLABEL_LSB)
                       | ({14'h0000, retry_code} << `ARHF_Q1_RETRY_LSB)
                       | ({12'h000, pkt_tcode} << `ARHF_Q1_TCODE_LSB)
                       | {12'h000, `ARHF_PRIOR_CABLE};
    wire [31:0] q1 = {dst_id, q1_lo};
    wire [15:0] q2_lo = is_resp(pkt_tcode) ?
                       ({12'h000, pkt_rcode} << `ARHF_Q2_RCODE_LSB) :
                       pkt_offset[47:32];
    wire [31:0] q2 = {src_id, q2_lo};
    wire [31:0] q3 = pkt_offset[31:0];
    // write responses carry no length; count is payload bytes only
    wire        len_used = (pkt_tcode != `ARHF_TC_WR_RESP);
    wire [31:0] q4 = {len_used ? pkt_length : 16'h0000,
                      pkt_ext_tcode};

    wire [2:0] nhdr = pkt_block ? `ARHF_HDR_N_BLK : `ARHF_HDR_N_QUAD;
    wire [15:0] dq_cnt = pkt_block ?
                       ((pkt_length + `ARHF_QUAD_BYTES - 16'h0001) >> 2) :
                       16'h0001;

    // ----------------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------------
    reg [3:0]  state_q;
    reg [2:0]  hidx_q;
    reg [15:0] dleft_q;
    wire       f_in_ready;
    reg        f_valid;
    reg [31:0] f_data;

    always @* begin
        f_valid = 1'b0;
        f_data  = 32'h00000000;
        case (state_q)
            S_HDR: begin
                f_valid = 1'b1;
                case (hidx_q)
                    3'h0:    f_data = q0;
                    3'h1:    f_data = q1;
                    3'h2:    f_data = q2;
                    3'h3:    f_data = q3;
                    default: f_data = q4;
                endcase
            end
            S_DATA: begin
                f_valid = dat_valid;
                f_data  = dat_quad;
            end
            default: f_valid = 1'b0;
        endcase
    end

    assign dat_ready = (state_q == S_DATA) && f_in_ready;
    assign pkt_ready = (state_q == S_DONE);

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q       <= S_IDLE;
            hidx_q        <= 3'h0;
            dleft_q       <= 16'h0000;
            entry_done    <= 1'b0;
            last_status_q <= 4'h0;
        end else begin
            entry_done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    hidx_q <= 3'h0;
                    if (pkt_valid) begin
                        state_q       <= S_HDR;
                        last_status_q <= status_d;
                        dleft_q <= has_data(pkt_tcode) ? dq_cnt : 16'h0000;
                    end
                end
                S_HDR: begin
                    if (f_in_ready) begin
                        if (hidx_q == nhdr - 3'h1)
                            state_q <= (dleft_q != 16'h0000) ?
                                       S_DATA : S_DONE;
                        else
                            hidx_q <= hidx_q + 3'h1;
                    end
                end
                S_DATA: begin
                    if (dat_valid && f_in_ready) begin
                        dleft_q <= dleft_q - 16'h0001;
                        if (dleft_q == 16'h0001)
                            state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    entry_done <= 1'b1;
                    state_q    <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // receive fifo; back-pressure stalls the sequencer
    // ----------------------------------------------------------------------
    arhf_fifo #(
        .W  (32),
        .D  (FIFO_DEPTH),
        .AW (FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (f_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_data),
        .out_valid (async_receive_fifo_valid),
        .out_ready (async_receive_fifo_ready),
        .out_data  (async_receive_fifo_data),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );
endmodule // arhf_formatter

//--- hw/arhf_regs.vh
/*
 * constants for the asynchronous receive header formatter: status codes,
 * speed codes, field positions and transaction codes of stored entries.
 * assumes a plain verilog-2005 tool flow; included by bare name.
 */
`ifndef ARHF_REGS_VH
`define ARHF_REGS_VH

// ----------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------
`define ARHF_ST_ACK_COMPLETE  4'h0
`define ARHF_ST_NO_ACK        4'h1
`define ARHF_ST_PTR_FETCH     4'h9
`define ARHF_ST_RCODE_BAD     4'ha
`define ARHF_ST_RSVD_LO       4'hb

// ----------------------------------------------------------------------
// speed codes and misc values
// ----------------------------------------------------------------------
`define ARHF_SPD_100          2'h0
`define ARHF_SPD_200          2'h1
`define ARHF_SPD_400          2'h2
`define ARHF_SPD_UNDEF        2'h3
`define ARHF_PRIOR_CABLE      4'h0
`define ARHF_RCODE_COMPLETE   4'h0

// ----------------------------------------------------------------------
// transaction codes
// ----------------------------------------------------------------------
`define ARHF_TC_WRQ_QUAD      4'h0
`define ARHF_TC_WRQ_BLK       4'h1
`define ARHF_TC_WR_RESP       4'h2
`define ARHF_TC_RRQ_QUAD      4'h4
`define ARHF_TC_RRQ_BLK       4'h5
`define ARHF_TC_RD_RESP_QUAD  4'h6
`define ARHF_TC_RD_RESP_BLK   4'h7
`define ARHF_TC_LOCK_RQ       4'h9
`define ARHF_TC_LOCK_RESP     4'hb

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ARHF_Q0_STATUS_LSB    28
`define ARHF_Q0_SPD_LSB       16
`define ARHF_Q1_TLABEL_LSB    10
`define ARHF_Q1_RETRY_LSB     8
`define ARHF_Q1_TCODE_LSB     4
`define ARHF_Q2_RCODE_LSB     12
`define ARHF_ID_NODE_W        6
`define ARHF_LEN_LSB          16
`define ARHF_QUAD_BYTES       16'h0004
`define ARHF_HDR_N_QUAD       3'h4
`define ARHF_HDR_N_BLK        3'h5

`endif

//--- hw/arhf_fifo.v
/*
 * synchronous fifo, parameterised width and depth, registered read data.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module arhf_fifo #(
    parameter W  = 32,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire          mclk,
    input  wire          resetn,
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    output reg           out_valid,
    input  wire          out_ready,
    output reg  [W-1:0]  out_data,
    output wire          full,
    output wire          empty
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0]  wr_q;
    reg [AW:0]  rd_q;
    wire [AW:0] cnt    = wr_q - rd_q;
    wire        mem_e  = (cnt == {(AW+1){1'b0}});
    wire        load   = !mem_e && (!out_valid || out_ready);

    assign full     = (cnt == D[AW:0]);
    assign in_ready = !full;
    assign empty    = mem_e && !out_valid;

    always @(posedge mclk) begin
        if (in_valid && in_ready)
            mem[wr_q[AW-1:0]] <= in_data;
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_q      <= {(AW+1){1'b0}};
            rd_q      <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else begin
            if (in_valid && in_ready)
                wr_q <= wr_q + 1'b1;
            if (load) begin
                out_data  <= mem[rd_q[AW-1:0]];
                rd_q      <= rd_q + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // arhf_fifo

//--- test/arhf_props.sv
/* checker on the formatter ports: handshake timing, status, fifo.
   assumes one 40 mhz mclk and an async active-low resetn. */
`timescale 1ns/100ps
module arhf_props (
    input wire        mclk,
    input wire        resetn,
    input wire        pkt_valid,
    input wire        pkt_ready,
    input wire        pkt_ptr_fetch,
    input wire        pkt_no_ack,
    input wire [3:0]  pkt_tcode,
    input wire [3:0]  pkt_rcode,
    input wire        dat_ready,
    input wire        async_receive_fifo_valid,
    input wire        async_receive_fifo_ready,
    input wire [31:0] async_receive_fifo_data,
    input wire        fifo_full,
    input wire        fifo_empty,
    input wire        entry_done,
    input wire [3:0]  last_status_q
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire rsp = pkt_tcode == 4'h2 || pkt_tcode == 4'h6 || pkt_tcode == 4'h7
        || pkt_tcode == 4'hb;
    wire bad = rsp && pkt_rcode != 4'h0;
    ready_pulse_a: assert property (pkt_ready |=> !pkt_ready)
        else $error("pkt_ready held past one cycle");
    done_next_a: assert property (pkt_ready |=> entry_done)
        else $error("entry_done missing after pkt_ready");
    done_cause_a: assert property (entry_done |-> $past(pkt_ready))
        else $error("entry_done without pkt_ready");
    hdr_min_a: assert property ($rose(pkt_valid) |-> !pkt_ready [*5])
        else $error("entry shorter than four header quadlets");
    st_ptr_a: assert property (pkt_ready && pkt_ptr_fetch
        |=> last_status_q == 4'h9) else $error("pointer fetch status");
    st_rcode_a: assert property (pkt_ready && !pkt_ptr_fetch && bad
        |=> last_status_q == 4'ha) else $error("bad rcode status");
    st_noack_a: assert property (pkt_ready && !pkt_ptr_fetch && !bad
        && pkt_no_ack |=> last_status_q == 4'h1) else $error("no-ack status");
    st_rsvd_a: assert property (entry_done |-> last_status_q < 4'hb)
        else $error("reserved status written");
    full_stall_a: assert property (fifo_full |-> !dat_ready)
        else $error("payload taken while fifo full");
    out_hold_a: assert property (async_receive_fifo_valid &&
        !async_receive_fifo_ready |=> async_receive_fifo_valid &&
        $stable(async_receive_fifo_data)) else $error("fifo output moved");
    flag_excl_a: assert property (!(fifo_full && fifo_empty))
        else $error("fifo both full and empty");
    cover property (pkt_ready && pkt_ptr_fetch);
    cover property (pkt_ready && bad);
    cover property (fifo_full);
endmodule // arhf_props

bind arhf_formatter arhf_props i_props (.mclk, .resetn, .pkt_valid,
    .pkt_ready, .pkt_ptr_fetch, .pkt_no_ack, .pkt_tcode, .pkt_rcode,
    .dat_ready, .async_receive_fifo_valid, .async_receive_fifo_ready,
    .async_receive_fifo_data, .fifo_full, .fifo_empty, .entry_done,
    .last_status_q);

//--- test/arhf_host.sv
/* host model draining the receive fifo into a queue.
   assumes the formatter's clock; stalls one cycle in three, all
   the time while hold is high, so the fifo can be filled. */
`timescale 1ns/100ps
module arhf_host (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        hold,
    input  wire        valid,
    input  wire [31:0] data,
    output reg         ready
);
    logic [31:0] got[$];
    logic [1:0]  ph_q;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ready <= 1'b0;
            ph_q  <= 2'h0;
        end else begin
            if (valid && ready)
                got.push_back(data);
            ph_q  <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            ready <= !hold && ph_q != 2'h0;
        end
    end
endmodule // arhf_host

//--- test/tb_top.sv
/* bench for the receive header formatter: random and corner packets,
   entries compared word by word once the host model has drained the fifo.
   assumes formatter, checker and host model are compiled first. */
`timescale 1ns/100ps
module tb_top;
    reg          mclk, resetn, pkt_valid, pkt_block, pkt_ptr_fetch;
    reg          pkt_no_ack, dat_valid, hold;
    reg  [3:0]   pkt_status_in, pkt_ack, pkt_tcode, pkt_rcode;
    reg  [1:0]   pkt_spd, retry_code;
    reg  [9:0]   pkt_dst_bus, pkt_src_bus;
    reg  [5:0]   pkt_dst_node, pkt_src_node, pkt_tlabel;
    reg  [47:0]  pkt_offset;
    reg  [15:0]  pkt_length, pkt_ext_tcode;
    reg  [31:0]  dat_quad;
    wire         pkt_ready, dat_ready, fifo_full, fifo_empty, entry_done;
    wire         async_receive_fifo_valid, async_receive_fifo_ready;
    wire [31:0]  async_receive_fifo_data;
    wire [3:0]   last_status_q;
    integer      n_errors, checked, seed, i, j;
    logic [31:0] exp_q[$], msk_q[$], w;
    logic [3:0]  tcs [0:8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
                               4'h9, 4'hb};

    arhf_formatter #(.FIFO_DEPTH(32), .FIFO_AW(5)) i_dut (.mclk, .resetn,
        .pkt_valid, .pkt_ready, .pkt_block, .pkt_ptr_fetch, .pkt_no_ack,
        .pkt_status_in, .pkt_spd, .pkt_ack, .pkt_dst_bus, .pkt_dst_node,
        .pkt_src_bus, .pkt_src_node, .pkt_tlabel, .retry_code, .pkt_tcode,
        .pkt_rcode, .pkt_offset, .pkt_length, .pkt_ext_tcode, .dat_valid,
        .dat_ready, .dat_quad, .async_receive_fifo_valid,
        .async_receive_fifo_ready, .async_receive_fifo_data, .fifo_full,
        .fifo_empty, .entry_done, .last_status_q);
    arhf_host i_host (.mclk, .resetn, .hold,
        .valid(async_receive_fifo_valid), .data(async_receive_fifo_data),
        .ready(async_receive_fifo_ready));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task stop_test;
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task put(input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back(v & m);
        msk_q.push_back(m);
    endtask

    // priority: pointer fetch, then bad response code, then no-ack
    function logic [3:0] exp_st(input p, input na, input rb,
        input [3:0] si);
        if (p)
            return 4'h9;
        if (rb)
            return 4'ha;
        if (na)
            return 4'h1;
        return (si >= 4'hb) ? 4'h0 : si;
    endfunction

    task automatic send(input [3:0] tc, input [15:0] len);
        logic [63:0] r, s;
        logic [31:0] dq[$];
        logic        rsp, blk;
        logic [3:0]  st;
        integer      nd, k;
        rsp = tc == 4'h2 || tc == 4'h6 || tc == 4'h7 || tc == 4'hb;
        blk = tc == 4'h1 || tc == 4'h5 || tc == 4'h7 || tc[3];
        nd = (tc == 4'h0 || tc == 4'h6) ? 1 :
            (blk && tc != 4'h5) ? (len + 3) / 4 : 0;
        r = {$random(seed), $random(seed)};
        s = {$random(seed), $random(seed)};
        @(posedge mclk);
        pkt_valid <= 1'b1;
        pkt_block <= blk;
        pkt_tcode <= tc;
        pkt_length <= len;
        {pkt_spd, pkt_ack, pkt_dst_bus, pkt_dst_node, pkt_src_bus,
            pkt_src_node, pkt_tlabel, retry_code} <= r[45:0];
        {pkt_offset, pkt_ext_tcode} <= {s[63:18], 2'h0, s[15:0]};
        {pkt_rcode, pkt_status_in} <= r[63:56] & {{4{r[55]}}, 4'hf};
        pkt_ptr_fetch <= r[54:52] == 3'h0;
        pkt_no_ack <= r[51:50] == 2'h0;
        dat_valid <= nd > 0;
        dat_quad <= $random(seed);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            if (dat_valid && dat_ready) begin
                dq.push_back(dat_quad);
                dat_valid <= dq.size() < nd;
                dat_quad <= $random(seed);
            end
        end while (!pkt_ready && k < 400);
        if (k >= 400) begin
            n_errors++;
            stop_test;
        end
        pkt_valid <= 1'b0;
        dat_valid <= 1'b0;
        st = exp_st(pkt_ptr_fetch, pkt_no_ack, rsp && pkt_rcode != 4'h0,
            pkt_status_in);
        put({st, 10'h0, pkt_spd == 2'h3 ? 2'h0 : pkt_spd, 12'h0, pkt_ack},
            '1);
        put({pkt_dst_bus, pkt_dst_node, pkt_tlabel, retry_code, tc, 4'h0},
            '1);
        put({pkt_src_bus, pkt_src_node, rsp ? {pkt_rcode, 12'h0} :
            pkt_offset[47:32]}, rsp ? 32'hfffff000 : '1);
        put(pkt_offset[31:0], '1);
        if (blk)
            put({len, pkt_ext_tcode}, '1);
        foreach (dq[n])
            put(dq[n], '1);
        @(posedge mclk);
        check(32'(entry_done), 32'h1);
        check(32'(last_status_q), 32'(st));
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        n_errors = 0;
        checked = 0;
        seed = 14288;
        {resetn, pkt_valid, pkt_block, pkt_ptr_fetch, pkt_no_ack,
            dat_valid, hold, pkt_status_in, pkt_ack, pkt_tcode, pkt_rcode,
            pkt_spd, retry_code, pkt_dst_bus, pkt_src_bus, pkt_dst_node,
            pkt_src_node, pkt_tlabel, pkt_offset, pkt_length,
            pkt_ext_tcode, dat_quad} = '0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        check(32'(fifo_empty), 32'h1);
        for (i = 0; i < 27; i++)
            send(tcs[i % 9], 16'($random(seed)) % 16'd21);
        send(4'h1, 16'h0001);
        send(4'h7, 16'h0000);
        send(4'h9, 16'h0004);
        // host stalled so a long block fills the 32-word fifo and stalls the payload
        hold <= 1'b1;
        fork
            send(4'h1, 16'd160);
            begin
                for (j = 0; j < 300 && !fifo_full; j++)
                    @(posedge mclk);
                repeat (4) @(posedge mclk);
                check(32'({fifo_full, dat_ready}), 32'h2);
                hold <= 1'b0;
            end
        join
        for (j = 0; j < 600 && !fifo_empty; j++)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        check(32'(fifo_empty), 32'h1);
        check(i_host.got.size(), exp_q.size());
        foreach (exp_q[n]) begin
            w = i_host.got[n] & msk_q[n];
            check(w, exp_q[n]);
        end
        stop_test;
    end
endmodule // tb_top
